// ===== crt_addr_pkg.sv
// Package with register offsets, field positions and reset values of the addressing block.
package crt_addr_pkg;
  localparam int ADDR_W = 14;
  localparam int REG_A_W = 5;
  localparam int SCAN_W = 5;
  // Register indices on the register port.
  localparam logic [4:0] OFF_MODE      = 5'h08;
  localparam logic [4:0] OFF_CUR_FIRST = 5'h0a;
  localparam logic [4:0] OFF_CUR_LAST  = 5'h0b;
  localparam logic [4:0] OFF_START_HI  = 5'h0c;
  localparam logic [4:0] OFF_START_LO  = 5'h0d;
  localparam logic [4:0] OFF_CUR_HI    = 5'h0e;
  localparam logic [4:0] OFF_CUR_LO    = 5'h0f;
  localparam logic [4:0] OFF_PEN_HI    = 5'h10;
  localparam logic [4:0] OFF_PEN_LO    = 5'h11;
  localparam logic [4:0] OFF_STATUS    = 5'h12;
  // Field positions.
  localparam int MODE_ROWCOL_BIT = 2;
  localparam int MODE_DE_DLY_BIT = 4;
  localparam int MODE_CUR_DLY_BIT = 5;
  localparam int CUR_MODE_LSB = 5;
  localparam int STAT_VBLANK_BIT = 5;
  localparam int STAT_PEN_BIT = 6;
  localparam int BLINK16_BIT = 3;
  localparam int BLINK32_BIT = 4;
  // Values after reset.
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [6:0] CUR_FIRST_RST = 7'h00;
  localparam logic [4:0] CUR_LAST_RST = 5'h00;
  localparam logic [13:0] ADDR_RST = 14'h0000;
  // Cursor modes in the order of their two-bit codes.
  typedef enum logic [1:0] {CUR_STEADY, CUR_OFF, CUR_BLINK16, CUR_BLINK32} cursor_mode_t;
endpackage : crt_addr_pkg

// ===== crt_skew.sv
// Optional one character clock delay stage for a video output.
`timescale 1ns/1ps
module crt_skew (
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Delay select and signal.
  input  wire logic i_sel,
  input  wire logic i_d,
  output logic      o_q
);
  import crt_addr_pkg::*;

  typedef struct packed {
    logic dly;
  } skew_state_t;

  skew_state_t state_reg;
  skew_state_t state_next;

  // The delayed copy always runs so that switching the select to the delayed copy never loses a cycle of data.
  always_comb begin
    state_next = state_reg;
    state_next.dly = i_d;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Select the skewed or the direct copy.
  assign o_q = i_sel ? state_reg.dly : i_d; // see (R7) see (R15)

  property p_skew_delay;
    @(posedge i_clk) disable iff (i_rst)
      i_sel |-> (o_q == $past(i_d));
  endproperty
  a_skew_delay: assert property (p_skew_delay) else $error("skew stage did not delay by one clock"); // see (R7)
endmodule : crt_skew

// ===== crt_cursor_addr.sv
// Cursor, display start, light pen and address format logic of a raster display controller.
// Overview of operation
// (R1) A 7-bit and a 5-bit register hold first and last cursor scan lines; the low 5 bits of the first give its scan line.
// (R2) Mode bits 6,5: steady, suppressed, blink field/16, blink field/32.
// (R3) The 14-bit start value is output as the first address of each field.
// (R4) The address advances on each character clock while display is enabled.
// (R5) A newly written start value takes effect from the next field; in row/column format the code uses a new low byte from the next row step.
// (R6) Cursor is active on address match with scan line inside the window.
// (R7) Mode bit 5 delays the cursor output by one character clock.
// (R8) Mode bit 4 selects delayed display enable, bit 5 delayed cursor.
// (R9) A rising pen strobe captures the address counter into the pen pair.
// (R10) Mode bit 2 selects straight binary or row/column address format.
// (R11) In row/column format low byte is column, high byte is row.
// (R12) Status bit 5 reads 1 during vertical blanking.
// (R13) Outside logic gives host addresses priority over ours on request.
// (R14) Outside logic interleaves our addresses and host addresses by clock phase; the raster model has no interleaving, only i_host_req selects.
// (R15) Delayed display enable lags by one character clock, like the cursor.
`timescale 1ns/1ps
module crt_cursor_addr (
  // Character clock and reset.
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // Register port.
  input  wire logic [crt_addr_pkg::REG_A_W-1:0] i_addr,
  input  wire logic [7:0]                  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [7:0]                  o_rdata,
  // Raster timing from the sync counters.
  input  wire logic                        i_field_start,
  input  wire logic                        i_line_start,
  input  wire logic                        i_row_done,
  input  wire logic                        i_disp_en,
  input  wire logic                        i_vblank,
  input  wire logic [crt_addr_pkg::SCAN_W-1:0] i_scan_row_addr,
  // Light pen pin.
  input  wire logic                        i_pen_strobe_in,
  // Video outputs.
  output logic      [crt_addr_pkg::ADDR_W-1:0] o_video_mem_addr,
  output logic                             o_cursor,
  output logic                             o_disp_en
);
  import crt_addr_pkg::*;

  typedef struct packed {
    logic [7:0]  mode_control_reg;
    logic [6:0]  cur_first;
    logic [4:0]  cur_last;
    logic [13:0] start;
    logic [13:0] cursor;
    logic [13:0] pen;
    logic        pen_full;
    logic [13:0] addr;
    logic [13:0] row_base;
    logic [4:0]  field_cnt;
    logic        pen_s1;
    logic        pen_s2;
    logic        pen_s3;
    logic        cur_q;
    logic        de_q;
    logic [7:0]  rdata;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic         rowcol;
  logic         in_window;
  logic         addr_match;
  logic         blink_on;
  logic         cursor_show;
  logic         pen_rise;
  logic [13:0]  addr_inc;
  logic [13:0]  row_next;
  logic [7:0]   rd_mux;
  cursor_mode_t cur_mode;

  // Decode of mode and cursor controls.
  assign rowcol = state_reg.mode_control_reg[MODE_ROWCOL_BIT]; // see (R10)
  assign cur_mode = cursor_mode_t'(state_reg.cur_first[CUR_MODE_LSB +: 2]);
  assign in_window = (i_scan_row_addr >= state_reg.cur_first[4:0])
                  && (i_scan_row_addr <= state_reg.cur_last); // see (R1) see (R6)
  assign addr_match = (state_reg.addr == state_reg.cursor) && i_disp_en; // see (R6)
  assign pen_rise = state_reg.pen_s2 && !state_reg.pen_s3;

  // Blink phase comes from the field counter, so the rate tracks the field rate.
  always_comb begin
    unique case (cur_mode)
      CUR_STEADY:  blink_on = 1'b1; // see (R2)
      CUR_OFF:     blink_on = 1'b0; // see (R2)
      CUR_BLINK16: blink_on = state_reg.field_cnt[BLINK16_BIT]; // see (R2)
      CUR_BLINK32: blink_on = state_reg.field_cnt[BLINK32_BIT]; // see (R2)
    endcase
  end

  assign cursor_show = addr_match && in_window && blink_on; // see (R6)

  // In row/column form only the column byte counts; the row byte is stepped per row.
  always_comb begin
    if (rowcol) begin
      addr_inc = {state_reg.addr[13:8], state_reg.addr[7:0] + 8'h01}; // see (R11)
      row_next = {state_reg.row_base[13:8] + 6'h01, state_reg.start[7:0]}; // see (R11)
    end else begin
      addr_inc = state_reg.addr + 14'h0001; // see (R4)
      row_next = state_reg.addr; // see (R10)
    end
  end

  // Read multiplexer; write-only and unmapped indices read as zero.
  always_comb begin
    rd_mux = 8'h00;
    unique case (i_addr)
      OFF_CUR_HI: rd_mux = {2'h0, state_reg.cursor[13:8]};
      OFF_CUR_LO: rd_mux = state_reg.cursor[7:0];
      OFF_PEN_HI: rd_mux = {2'h0, state_reg.pen[13:8]};
      OFF_PEN_LO: rd_mux = state_reg.pen[7:0];
      OFF_STATUS: begin
        rd_mux[STAT_VBLANK_BIT] = i_vblank; // see (R12)
        rd_mux[STAT_PEN_BIT] = state_reg.pen_full;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // Next state of the whole block.
  always_comb begin
    state_next = state_reg;
    state_next.rdata = i_rd ? rd_mux : 8'h00;
    // The pen pin is asynchronous, so it passes two flops before the edge detect.
    state_next.pen_s1 = i_pen_strobe_in;
    state_next.pen_s2 = state_reg.pen_s1;
    state_next.pen_s3 = state_reg.pen_s2;
    // Register writes.
    if (i_wr) begin
      unique case (i_addr)
        OFF_MODE:      state_next.mode_control_reg = i_wdata; // see (R8)
        OFF_CUR_FIRST: state_next.cur_first = i_wdata[6:0]; // see (R1) see (R2)
        OFF_CUR_LAST:  state_next.cur_last = i_wdata[4:0]; // see (R1)
        OFF_START_HI:  state_next.start[13:8] = i_wdata[5:0]; // see (R5)
        OFF_START_LO:  state_next.start[7:0] = i_wdata; // see (R5)
        OFF_CUR_HI:    state_next.cursor[13:8] = i_wdata[5:0];
        OFF_CUR_LO:    state_next.cursor[7:0] = i_wdata;
        default:       state_next.cursor = state_reg.cursor;
      endcase
    end
    // The capture flag is cleared by reading the low pen byte.
    if (i_rd && (i_addr == OFF_PEN_LO)) begin
      state_next.pen_full = 1'b0;
    end
    // A capture in the same cycle as the clearing read wins.
    if (pen_rise) begin
      state_next.pen = state_reg.addr; // see (R9)
      state_next.pen_full = 1'b1;
    end
    // Address counter: field load beats row step, row step beats line reload.
    if (i_field_start) begin
      state_next.addr = state_reg.start; // see (R3) see (R5)
      state_next.row_base = state_reg.start; // see (R3)
      state_next.field_cnt = state_reg.field_cnt + 5'h01; // see (R2)
    end else if (i_row_done) begin
      state_next.addr = row_next; // see (R10)
      state_next.row_base = row_next;
    end else if (i_line_start) begin
      state_next.addr = state_reg.row_base;
    end else if (i_disp_en) begin
      state_next.addr = addr_inc; // see (R4)
    end
    // Outputs are registered once here; the skew stages may add one more clock.
    state_next.cur_q = cursor_show;
    state_next.de_q = i_disp_en;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= '0;
      state_reg.mode_control_reg <= MODE_RST;
      state_reg.cur_first <= CUR_FIRST_RST;
      state_reg.cur_last <= CUR_LAST_RST;
      state_reg.start <= ADDR_RST;
      state_reg.cursor <= ADDR_RST;
      state_reg.addr <= ADDR_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Optional skew of cursor and display enable for slow display memories.
  crt_skew u_cursor_skew (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_sel (state_reg.mode_control_reg[MODE_CUR_DLY_BIT]), // see (R7) see (R8)
    .i_d   (state_reg.cur_q),
    .o_q   (o_cursor)
  );

  crt_skew u_de_skew (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_sel (state_reg.mode_control_reg[MODE_DE_DLY_BIT]), // see (R8) see (R15)
    .i_d   (state_reg.de_q),
    .o_q   (o_disp_en)
  );

  assign o_video_mem_addr = state_reg.addr; // see (R3)
  assign o_rdata = state_reg.rdata;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_start_lo_write;
    i_wr && (i_addr == OFF_START_LO);
  endsequence

  sequence s_quiet_then_field;
    (!i_wr) ##1 i_field_start;
  endsequence

  property p_field_load;
    i_field_start |=> (o_video_mem_addr == $past(state_reg.start));
  endproperty
  a_field_load: assert property (p_field_load) else $error("field did not start at start value"); // see (R3)

  property p_advance;
    (i_disp_en && !rowcol && !i_field_start && !i_row_done && !i_line_start)
      |=> (o_video_mem_addr == $past(o_video_mem_addr) + 14'h0001);
  endproperty
  a_advance: assert property (p_advance) else $error("address did not advance"); // see (R4)

  property p_scroll;
    s_start_lo_write ##1 s_quiet_then_field |=> (o_video_mem_addr[7:0] == $past(i_wdata, 3));
  endproperty
  a_scroll: assert property (p_scroll) else $error("new start value not used"); // see (R5)

  property p_suppress;
    (cur_mode == CUR_OFF) |=> !state_reg.cur_q;
  endproperty
  a_suppress: assert property (p_suppress) else $error("suppressed cursor shown"); // see (R2)

  property p_cursor_cause;
    (state_reg.mode_control_reg[MODE_CUR_DLY_BIT] == 1'b0) && o_cursor
      |-> $past(addr_match && in_window);
  endproperty
  a_cursor_cause: assert property (p_cursor_cause) else $error("cursor without match"); // see (R6)

  property p_cursor_delay;
    state_reg.mode_control_reg[MODE_CUR_DLY_BIT] && $past(state_reg.mode_control_reg[5])
      |-> (o_cursor == $past(cursor_show, 2));
  endproperty
  a_cursor_delay: assert property (p_cursor_delay) else $error("cursor not delayed"); // see (R7)

  property p_de_direct;
    !state_reg.mode_control_reg[MODE_DE_DLY_BIT] |-> (o_disp_en == $past(i_disp_en));
  endproperty
  a_de_direct: assert property (p_de_direct) else $error("display enable wrong"); // see (R8)

  property p_de_delay;
    state_reg.mode_control_reg[MODE_DE_DLY_BIT] && $past(state_reg.mode_control_reg[4])
      |-> (o_disp_en == $past(i_disp_en, 2));
  endproperty
  a_de_delay: assert property (p_de_delay) else $error("display enable not delayed"); // see (R15)

  property p_pen_capture;
    pen_rise |=> (state_reg.pen == $past(state_reg.addr)) && state_reg.pen_full;
  endproperty
  a_pen_capture: assert property (p_pen_capture) else $error("pen position not captured"); // see (R9)

  property p_rowcol_hold;
    (rowcol && i_disp_en && !i_field_start && !i_row_done && !i_line_start)
      |=> (o_video_mem_addr[13:8] == $past(o_video_mem_addr[13:8]));
  endproperty
  a_rowcol_hold: assert property (p_rowcol_hold) else $error("row byte moved within row"); // see (R11)

  property p_status_vblank;
    (i_rd && (i_addr == OFF_STATUS)) |=> (o_rdata[STAT_VBLANK_BIT] == $past(i_vblank));
  endproperty
  a_status_vblank: assert property (p_status_vblank) else $error("retrace status wrong"); // see (R12)

  property p_row_step_rowcol;
    (rowcol && i_row_done && !i_field_start)
      |=> (o_video_mem_addr[13:8] == $past(state_reg.row_base[13:8]) + 6'h01);
  endproperty
  a_row_step_rowcol: assert property (p_row_step_rowcol) else $error("row not stepped"); // see (R10)
endmodule : crt_cursor_addr

// ===== crt_raster_model.sv
// Raster timing source and video memory address selector facing the addressing block.
`timescale 1ns/1ps
module crt_raster_model #(
  parameter int COLS  = 4,
  parameter int LINES = 3,
  parameter int ROWS  = 2,
  parameter int VBL   = 2
) (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Address sources for the video memory.
  input  wire logic        i_host_req,
  input  wire logic [13:0] i_host_addr,
  input  wire logic [13:0] i_ctl_addr,
  // Raster timing and beam position.
  output logic             o_field_start,
  output logic             o_line_start,
  output logic             o_row_done,
  output logic             o_disp_en,
  output logic             o_vblank,
  output logic [4:0]       o_scan_row_addr,
  output logic [7:0]       o_row,
  output logic [7:0]       o_col,
  output logic [13:0]      o_mem_addr
);
  int h_reg;
  int ln_reg;
  // A scan line is a start slot, COLS shown characters and a closing slot.
  always_ff @(posedge i_clk) begin
    if (i_rst || h_reg == COLS + 1) begin
      h_reg <= 0;
    end else begin
      h_reg <= h_reg + 1;
    end
    if (i_rst) begin
      ln_reg <= 0;
    end else if (h_reg == COLS + 1) begin
      ln_reg <= (ln_reg == ROWS * LINES + VBL - 1) ? 0 : ln_reg + 1;
    end
  end
  // No line starts in blanking, so the address counter rests there for pen tests.
  always_comb begin
    o_vblank        = ln_reg >= ROWS * LINES;
    o_field_start   = h_reg == 0 && ln_reg == 0;
    o_line_start    = h_reg == 0 && !o_vblank;
    o_disp_en       = !o_vblank && h_reg >= 1 && h_reg <= COLS;
    o_row_done      = !o_vblank && h_reg == COLS + 1 && ln_reg % LINES == LINES - 1;
    o_scan_row_addr = o_vblank ? 5'h00 : 5'(ln_reg % LINES);
    o_row           = 8'(ln_reg / LINES);
    o_col           = 8'(h_reg - 1);
  end
  // A host request takes the memory; otherwise the controller address is passed on.
  assign o_mem_addr = i_host_req ? i_host_addr : i_ctl_addr;
endmodule : crt_raster_model

// ===== crt_cursor_addr_test.sv
// Self-checking testbench of the cursor and addressing block.
`timescale 1ns/1ps
module crt_cursor_addr_test;
  import crt_addr_pkg::*;
  localparam int COLS = 4;
  localparam int ROWS = 2;
  logic        i_clk, i_rst, i_wr, i_rd, i_pen_strobe_in;
  logic [4:0]  i_addr, m_scan, s_first, s_last;
  logic [7:0]  i_wdata, o_rdata, m_row, m_col;
  logic [13:0] o_video_mem_addr, s_st, s_cur;
  logic        m_fs, m_ls, m_rd, m_de, m_vb, o_cursor, o_disp_en, s_rc, s_de, s_cd;
  logic [1:0]  s_cm, sh, dh;
  int          fails = 0;
  int          samples_checked = 0;
  int          n;

  crt_raster_model #(.COLS(COLS), .LINES(3), .ROWS(ROWS), .VBL(2)) far (
    .i_clk(i_clk), .i_rst(i_rst), .i_host_req(1'b0), .i_host_addr(14'h0000),
    .i_ctl_addr(o_video_mem_addr), .o_field_start(m_fs), .o_line_start(m_ls),
    .o_row_done(m_rd), .o_disp_en(m_de), .o_vblank(m_vb), .o_scan_row_addr(m_scan),
    .o_row(m_row), .o_col(m_col), .o_mem_addr());
  crt_cursor_addr DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_field_start(m_fs), .i_line_start(m_ls),
    .i_row_done(m_rd), .i_disp_en(m_de), .i_vblank(m_vb), .i_scan_row_addr(m_scan),
    .i_pen_strobe_in(i_pen_strobe_in), .o_video_mem_addr(o_video_mem_addr),
    .o_cursor(o_cursor), .o_disp_en(o_disp_en));

  // Expected counter value at a shown character in the current format.
  function automatic logic [13:0] exp_a(input logic [7:0] r, input logic [7:0] c);
    if (s_rc) begin
      return {6'(s_st[13:8] + r), 8'(s_st[7:0] + c)};
    end
    return 14'(s_st + r * COLS + c);
  endfunction : exp_a

  // History of expected cursor and enable, so skewed outputs are judged later.
  always @(negedge i_clk) begin
    sh <= {sh[0], m_de && exp_a(m_row, m_col) == s_cur && s_cm != CUR_OFF
           && s_first <= m_scan && m_scan <= s_last};
    dh <= {dh[0], m_de};
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe, so it is taken there.
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(16'(o_rdata), 16'(e));
  endtask : rd

  task automatic cfg(input logic [7:0] m, input logic [13:0] st, input logic [13:0] cu,
                     input logic [6:0] f, input logic [4:0] l);
    {s_rc, s_de, s_cd} = {m[MODE_ROWCOL_BIT], m[MODE_DE_DLY_BIT], m[MODE_CUR_DLY_BIT]};
    {s_st, s_cur, s_cm, s_first, s_last} = {st, cu, f, l};
    wr(OFF_MODE, m);
    wr(OFF_CUR_FIRST, {1'b0, f});
    wr(OFF_CUR_LAST, {3'h0, l});
    wr(OFF_START_HI, {2'h0, st[13:8]});
    wr(OFF_START_LO, st[7:0]);
    wr(OFF_CUR_HI, {2'h0, cu[13:8]});
    wr(OFF_CUR_LO, cu[7:0]);
    @(negedge i_clk);
  endtask : cfg

  // One whole field from its start; returns the cursor cycles seen.
  task automatic field(input bit c, output int cnt);
    cnt = 0;
    while (!m_fs) @(negedge i_clk);
    do begin
      if (c && m_de) chk(16'(o_video_mem_addr), 16'(exp_a(m_row, m_col)));
      if (c) chk(16'(o_cursor), 16'(s_cd ? sh[1] : sh[0]));
      if (c) chk(16'(o_disp_en), 16'(s_de ? dh[1] : dh[0]));
      cnt += int'(o_cursor === 1'b1);
      @(negedge i_clk);
    end while (!m_fs);
  endtask : field

  task automatic t_regs;
    rd(OFF_CUR_HI, 8'h00);
    rd(OFF_STATUS, 8'h00);
    wr(OFF_CUR_HI, 8'hff);
    wr(OFF_CUR_LO, 8'ha5);
    wr(OFF_PEN_LO, 8'h5a);
    rd(OFF_CUR_HI, 8'h3f);
    rd(OFF_CUR_LO, 8'ha5);
    rd(OFF_PEN_LO, 8'h00);
    rd(OFF_START_LO, 8'h00);
    rd(5'h1f, 8'h00);
    $display("register test done");
  endtask : t_regs

  // Fields in binary and row/column format, including a start that wraps past the top of the 14-bit space.
  task automatic t_bin;
    cfg(8'h00, 14'h0100, 14'h0106, 7'h00, 5'h02);
    field(1'b1, n);
    chk(16'(n), 16'h0003);
    cfg(8'h00, 14'h3ffe, 14'h0003, 7'h01, 5'h01);
    field(1'b1, n);
    chk(16'(n), 16'h0001);
    cfg(8'h00, 14'h3ffe, 14'h0003, 7'h20, 5'h02);
    field(1'b1, n);
    chk(16'(n), 16'h0000);
    cfg(8'h04, 14'h0510, 14'h0612, 7'h00, 5'h02);
    field(1'b1, n);
    chk(16'(n), 16'h0003);
    cfg(8'h34, 14'h0510, 14'h0612, 7'h00, 5'h02);
    field(1'b1, n);
    chk(16'(n), 16'h0003);
    $display("field test done");
  endtask : t_bin

  // Longest run of equally lit fields tells the blink divider.
  task automatic t_blink(input logic [1:0] cm, input int run);
    int r;
    int mx;
    bit v;
    bit pv;
    {r, mx, pv} = '0;
    cfg(8'h00, 14'h0100, 14'h0106, {cm, 5'h00}, 5'h02);
    for (int k = 0; k < 48; k++) begin
      field(1'b0, n);
      v = n > 0;
      r = (k > 0 && v == pv) ? r + 1 : 1;
      mx = (r > mx) ? r : mx;
      pv = v;
    end
    chk(16'(mx), 16'(run));
    $display("blink test done");
  endtask : t_blink

  task automatic t_pen;
    logic [13:0] p;
    p = 14'h0123 + 14'(ROWS * COLS);
    cfg(8'h00, 14'h0123, 14'h0000, 7'h00, 5'h02);
    field(1'b0, n);
    while (!m_vb) @(negedge i_clk);
    @(posedge i_clk);
    i_pen_strobe_in <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_pen_strobe_in <= 1'b0;
    rd(OFF_STATUS, 8'h60);
    rd(OFF_PEN_HI, {2'h0, p[13:8]});
    rd(OFF_PEN_LO, p[7:0]);
    while (m_vb) @(negedge i_clk);
    rd(OFF_STATUS, 8'h00);
    $display("pen test done");
  endtask : t_pen

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // Watchdog set well beyond the roughly 5400 cycles the tests need.
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    summarize();
  end

  initial begin
    {i_rst, i_addr, i_wdata, i_wr, i_rd, i_pen_strobe_in} = {1'b1, 5'h00, 8'h00, 3'h0};
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    t_bin();
    t_blink(2'b10, 8);
    t_blink(2'b11, 16);
    t_pen();
    summarize();
  end
endmodule : crt_cursor_addr_test
